/* src/ccs_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RULE_01] host waits 500 ms after power
// [RULE_02] host waits command delay before reading
// [RULE_03] 0x40 returns accel xyz, high first
// [RULE_04] 0x45 returns mag xyz, high first
// [RULE_05] 0x50 returns heading, pitch, roll
// [RULE_06] 0x55 returns pitch, roll, temperature
// [RULE_07] 0x72 selects level orientation, default
// [RULE_08] 0x73 selects upright edge orientation
// [RULE_09] 0x74 selects upright front orientation
// [RULE_10] 0xf1 nonvolatile write, 10 ms settle
// [RULE_11] locations 0x04, 0x05 hold mode registers
// [RULE_12] host writes modes only for orientation/rate
// [RULE_13] mode bit 7 flags compass calculation
// [RULE_14] mode bit 6 flags offset calculation
// [RULE_15] mode bit 5 enables heading filter
// [RULE_16] bit 4 run, bit 3 standby
// [RULE_17] bits 2..0 front, edge, level orientation
// [RULE_18] host keeps rate bits 7..2 zero
// [RULE_19] rate bits: 1, 5, 10 Hz
// [RULE_20] 0x71 enters, 0x7e exits calibration
// [RULE_21] calibration exit replaces hard-iron offsets
// [RULE_22] heading 0..3600, tilt within +-900
// [RULE_23] commands arrive as write transfers
// [RULE_24] read bytes follow last command
module ccs_sequencer #(
  parameter int unsigned INIT_CYC  = ccs_pkg::T_INIT_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned DATA_CYC  = ccs_pkg::T_DATA_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned SHORT_CYC = ccs_pkg::T_SHORT_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned CALX_CYC  = ccs_pkg::T_CALX_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned RST_CYC   = ccs_pkg::T_RST_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned SLEEP_CYC = ccs_pkg::T_SLEEP_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned WAKE_CYC  = ccs_pkg::T_WAKE_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned NV_CYC    = ccs_pkg::T_NV_US * ccs_pkg::CLK_MHZ,
  parameter int unsigned RATE1_CYC = ccs_pkg::CLK_MHZ * 1000000 / ccs_pkg::RATE_LO_HZ,
  parameter int unsigned RATE5_CYC = ccs_pkg::CLK_MHZ * 1000000 / ccs_pkg::RATE_MID_HZ,
  parameter int unsigned RATE10_CYC = ccs_pkg::CLK_MHZ * 1000000 / ccs_pkg::RATE_HI_HZ
) (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    reset_i,
  // bytes written by the host
  input  wire logic                    wr_valid_i,
  input  wire logic                    wr_first_i,
  input  wire logic [7:0]              wr_data_i,
  // bytes read by the host
  input  wire logic                    rd_start_i,
  input  wire logic                    rd_req_i,
  output logic                         rd_valid_o,
  output logic [7:0]                   rd_data_o,
  output logic                         busy_o,
  // sensing datapath
  input  wire ccs_pkg::ccs_sample_type sample_i,
  input  wire logic                    sample_valid_i,
  input  wire logic                    calc_busy_i,
  output logic                         meas_tick_o,
  output logic [7:0]                   operating_mode_status_o,
  output logic [7:0]                   measurement_rate_config_o,
  output logic                         sleep_o,
  output ccs_pkg::ccs_offset_type      hard_iron_o
);
  import ccs_pkg::*;

  ccs_state_type     state_d, state_q;
  logic [31:0]       cnt_d, cnt_q;
  logic [31:0]       tick_cnt_d, tick_cnt_q;
  logic              tick_d, tick_q;
  logic [7:0]        cmd_d, cmd_q;
  logic [7:0]        arg_d, arg_q;
  logic [5:0]        om1_d, om1_q;
  logic [7:0]        om2_d, om2_q;
  logic              cal_d, cal_q;
  logic              calx_d, calx_q;
  logic              sleep_d, sleep_q;
  logic [7:0]        resp_d [RESP_BYTES];
  logic [7:0]        resp_q [RESP_BYTES];
  logic [2:0]        idx_d, idx_q;
  logic [7:0]        rdat_d, rdat_q;
  logic              rval_d, rval_q;
  logic signed [15:0] mn_d [3];
  logic signed [15:0] mn_q [3];
  logic signed [15:0] mx_d [3];
  logic signed [15:0] mx_q [3];
  ccs_offset_type    ofs_d, ofs_q;
  logic signed [15:0] mag [3];
  logic signed [15:0] ofs_new [3];
  logic [7:0]        om1_view;
  logic [31:0]       rate_cyc;

  function automatic logic [15:0] clamp(input logic signed [15:0] v,
                                        input logic signed [15:0] lo,
                                        input logic signed [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // command to answer delay
  function automatic logic [31:0] delay_of(input logic [7:0] c);
    case (c)
      CMD_ACCEL, CMD_MAG, CMD_HEAD, CMD_TILT, CMD_MODE: return 32'(DATA_CYC);
      CMD_CAL_OUT: return 32'(CALX_CYC);
      CMD_RESET:   return 32'(RST_CYC);
      CMD_SLEEP:   return 32'(SLEEP_CYC);
      CMD_WAKE:    return 32'(WAKE_CYC);
      CMD_NV_RD:   return 32'(NV_CYC);
      CMD_NV_WR:   return 32'(NV_CYC);
      default:     return 32'(SHORT_CYC);
    endcase
  endfunction

  assign mag[0] = sample_i.mag_x;
  assign mag[1] = sample_i.mag_y;
  assign mag[2] = sample_i.mag_z;

  // midpoint of collected extremes; 17 bits so the sum cannot wrap
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ofs
      logic signed [16:0] sum;
      assign sum        = 17'(mx_q[g]) + 17'(mn_q[g]);
      assign ofs_new[g] = sum[16:1]; // [RULE_21]
    end
  endgenerate

  assign om1_view = {calc_busy_i, cal_q | calx_q, om1_q}; // [RULE_13] [RULE_14]

  always_comb begin
    unique case (om2_q[1:0]) // [RULE_19]
      RATE_1HZ:  rate_cyc = 32'(RATE1_CYC);
      RATE_10HZ: rate_cyc = 32'(RATE10_CYC);
      default:   rate_cyc = 32'(RATE5_CYC);
    endcase
  end

  // rate divider, halted outside run or asleep
  always_comb begin
    tick_cnt_d = tick_cnt_q;
    tick_d     = 1'b0;
    if (!om1_q[OM_RUN] || sleep_q || state_q == ST_INIT) begin // [RULE_16]
      tick_cnt_d = '0;
    end else if (tick_cnt_q >= rate_cyc - 32'h1) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end else begin
      tick_cnt_d = tick_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // command interpreter
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    cmd_d   = cmd_q;
    arg_d   = arg_q;
    om1_d   = om1_q;
    om2_d   = om2_q;
    cal_d   = cal_q;
    calx_d  = calx_q;
    sleep_d = sleep_q;
    idx_d   = idx_q;
    rdat_d  = rdat_q;
    rval_d  = 1'b0;
    ofs_d   = ofs_q;
    for (int i = 0; i < RESP_BYTES; i++) begin
      resp_d[i] = resp_q[i];
    end
    for (int i = 0; i < 3; i++) begin
      mn_d[i] = mn_q[i];
      mx_d[i] = mx_q[i];
      if (cal_q && sample_valid_i) begin
        if (mag[i] < mn_q[i]) begin
          mn_d[i] = mag[i];
        end
        if (mag[i] > mx_q[i]) begin
          mx_d[i] = mag[i];
        end
      end
    end
    // reads answer from last command's buffer
    if (rd_start_i) begin
      idx_d = '0;
    end else if (rd_req_i) begin
      rval_d = 1'b1; // [RULE_24]
      rdat_d = (busy_o ||
                idx_q >= 3'(RESP_BYTES)) ? 8'h00 : resp_q[idx_q];
      if (idx_q < 3'(RESP_BYTES)) begin
        idx_d = idx_q + 3'h1;
      end
    end
    unique case (state_q)
      ST_INIT: begin
        // power-up and processor reset end in run mode
        if (cnt_q == '0) begin
          state_d = ST_IDLE; // [RULE_01]
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      ST_IDLE, ST_ARG1, ST_ARG2: begin
        if (wr_valid_i && wr_first_i) begin // [RULE_23]
          cmd_d = wr_data_i;
          idx_d = '0;
          for (int i = 0; i < RESP_BYTES; i++) begin
            resp_d[i] = 8'h00;
          end
          cnt_d = delay_of(wr_data_i);
          state_d = ST_BUSY;
          unique case (wr_data_i)
            CMD_ACCEL: begin
              {resp_d[0], resp_d[1]} = sample_i.acc_x; // [RULE_03]
              {resp_d[2], resp_d[3]} = sample_i.acc_y;
              {resp_d[4], resp_d[5]} = sample_i.acc_z;
            end
            CMD_MAG: begin
              {resp_d[0], resp_d[1]} = sample_i.mag_x; // [RULE_04]
              {resp_d[2], resp_d[3]} = sample_i.mag_y;
              {resp_d[4], resp_d[5]} = sample_i.mag_z;
            end
            CMD_HEAD: begin
              {resp_d[0], resp_d[1]} = clamp(sample_i.heading, '0, HEAD_MAX); // [RULE_05] [RULE_22]
              {resp_d[2], resp_d[3]} = clamp(sample_i.pitch, -TILT_MAX, TILT_MAX);
              {resp_d[4], resp_d[5]} = clamp(sample_i.roll, -TILT_MAX, TILT_MAX);
            end
            CMD_TILT: begin
              {resp_d[0], resp_d[1]} = clamp(sample_i.pitch, -TILT_MAX, TILT_MAX); // [RULE_06] [RULE_22]
              {resp_d[2], resp_d[3]} = clamp(sample_i.roll, -TILT_MAX, TILT_MAX);
              {resp_d[4], resp_d[5]} = sample_i.temp;
            end
            CMD_MODE: resp_d[0] = om1_view;
            CMD_LEVEL: om1_d[2:0] = ORI_LEVEL; // [RULE_07]
            CMD_EDGE:  om1_d[2:0] = ORI_EDGE; // [RULE_08]
            CMD_FRONT: om1_d[2:0] = ORI_FRONT; // [RULE_09]
            CMD_RUN: begin
              om1_d[OM_RUN]  = 1'b1; // [RULE_16]
              om1_d[OM_STBY] = 1'b0;
            end
            CMD_STBY: begin
              om1_d[OM_RUN]  = 1'b0;
              om1_d[OM_STBY] = 1'b1;
            end
            CMD_CAL_IN: begin
              cal_d = 1'b1; // [RULE_20]
              for (int i = 0; i < 3; i++) begin
                mn_d[i] = mag[i];
                mx_d[i] = mag[i];
              end
            end
            CMD_CAL_OUT: begin
              if (cal_q) begin
                cal_d  = 1'b0; // [RULE_20]
                calx_d = 1'b1;
              end
            end
            CMD_SLEEP: sleep_d = 1'b1;
            CMD_WAKE: begin
              sleep_d        = 1'b0;
              om1_d[OM_RUN]  = 1'b0;
              om1_d[OM_STBY] = 1'b1;
            end
            CMD_NV_RD, CMD_NV_WR: state_d = ST_ARG1;
            default: ;
          endcase
        end else if (wr_valid_i && state_q == ST_ARG1) begin
          arg_d = wr_data_i;
          if (cmd_q == CMD_NV_WR) begin
            state_d = ST_ARG2;
          end else begin
            state_d = ST_BUSY;
            unique case (wr_data_i)
              NV_MODE:          resp_d[0] = om1_view;
              NV_RATE:          resp_d[0] = om2_q;
              NV_XOFS_LO:       resp_d[0] = ofs_q.x[7:0];
              NV_XOFS_LO + 8'h1: resp_d[0] = ofs_q.x[15:8];
              NV_XOFS_LO + 8'h2: resp_d[0] = ofs_q.y[7:0];
              NV_XOFS_LO + 8'h3: resp_d[0] = ofs_q.y[15:8];
              NV_XOFS_LO + 8'h4: resp_d[0] = ofs_q.z[7:0];
              NV_XOFS_LO + 8'h5: resp_d[0] = ofs_q.z[15:8];
              default:          resp_d[0] = 8'h00;
            endcase
          end
        end else if (wr_valid_i && state_q == ST_ARG2) begin
          state_d = ST_BUSY; // [RULE_10]
          if (arg_q == NV_MODE) begin
            om1_d = wr_data_i[5:0] & OM_WR_MASK; // [RULE_11] [RULE_15]
          end else if (arg_q == NV_RATE) begin
            om2_d = wr_data_i; // [RULE_11]
          end
        end
      end
      ST_BUSY: begin
        // bytes written while busy are dropped
        if (cnt_q == '0) begin
          state_d = ST_IDLE; // [RULE_02] [RULE_10]
          if (calx_q) begin
            calx_d  = 1'b0;
            ofs_d.x = ofs_new[0]; // [RULE_21]
            ofs_d.y = ofs_new[1];
            ofs_d.z = ofs_new[2];
          end
          if (cmd_q == CMD_RESET) begin
            state_d = ST_INIT;
            cnt_d   = 32'(INIT_CYC);
            om1_d   = OM1_RESET[5:0];
            cal_d   = 1'b0;
            sleep_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_INIT;
      cnt_q   <= 32'(INIT_CYC);
      cmd_q   <= 8'h00;
      arg_q   <= 8'h00;
      om1_q   <= OM1_RESET[5:0]; // [RULE_16] [RULE_17]
      om2_q   <= OM2_RESET; // [RULE_19]
      cal_q   <= 1'b0;
      calx_q  <= 1'b0;
      sleep_q <= 1'b0;
      idx_q   <= '0;
      rdat_q  <= 8'h00;
      rval_q  <= 1'b0;
      ofs_q   <= '0;
      for (int i = 0; i < RESP_BYTES; i++) begin
        resp_q[i] <= 8'h00;
      end
      for (int i = 0; i < 3; i++) begin
        mn_q[i] <= '0;
        mx_q[i] <= '0;
      end
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cmd_q   <= cmd_d;
      arg_q   <= arg_d;
      om1_q   <= om1_d;
      om2_q   <= om2_d;
      cal_q   <= cal_d;
      calx_q  <= calx_d;
      sleep_q <= sleep_d;
      idx_q   <= idx_d;
      rdat_q  <= rdat_d;
      rval_q  <= rval_d;
      ofs_q   <= ofs_d;
      resp_q  <= resp_d;
      mn_q    <= mn_d;
      mx_q    <= mx_d;
    end
  end

  assign rd_valid_o                = rval_q;
  assign rd_data_o                 = rdat_q;
  assign busy_o                    = (state_q == ST_INIT) || (state_q == ST_BUSY);
  assign meas_tick_o               = tick_q;
  assign operating_mode_status_o   = om1_view;
  assign measurement_rate_config_o = om2_q;
  assign sleep_o                   = sleep_q;
  assign hard_iron_o               = ofs_q;
endmodule
`default_nettype wire

/* src/ccs_pkg.sv */
package ccs_pkg;
  // clock
  localparam int unsigned CLK_MHZ     = 125;
  // command to ready times, microseconds
  localparam int unsigned T_INIT_US   = 500000;
  localparam int unsigned T_DATA_US   = 1000;
  localparam int unsigned T_SHORT_US  = 300;
  localparam int unsigned T_CALX_US   = 50000;
  localparam int unsigned T_RST_US    = 500000;
  localparam int unsigned T_SLEEP_US  = 1000;
  localparam int unsigned T_WAKE_US   = 20000;
  localparam int unsigned T_NV_US     = 10000;
  // measurement rates, hertz
  localparam int unsigned RATE_LO_HZ  = 1;
  localparam int unsigned RATE_MID_HZ = 5;
  localparam int unsigned RATE_HI_HZ  = 10;
  // command codes
  localparam logic [7:0] CMD_ACCEL    = 8'h40;
  localparam logic [7:0] CMD_MAG      = 8'h45;
  localparam logic [7:0] CMD_HEAD     = 8'h50;
  localparam logic [7:0] CMD_TILT     = 8'h55;
  localparam logic [7:0] CMD_MODE     = 8'h65;
  localparam logic [7:0] CMD_CAL_IN   = 8'h71;
  localparam logic [7:0] CMD_LEVEL    = 8'h72;
  localparam logic [7:0] CMD_EDGE     = 8'h73;
  localparam logic [7:0] CMD_FRONT    = 8'h74;
  localparam logic [7:0] CMD_RUN      = 8'h75;
  localparam logic [7:0] CMD_STBY     = 8'h76;
  localparam logic [7:0] CMD_CAL_OUT  = 8'h7e;
  localparam logic [7:0] CMD_RESET    = 8'h82;
  localparam logic [7:0] CMD_SLEEP    = 8'h83;
  localparam logic [7:0] CMD_WAKE     = 8'h84;
  localparam logic [7:0] CMD_NV_RD    = 8'he1;
  localparam logic [7:0] CMD_NV_WR    = 8'hf1;
  // nonvolatile locations
  localparam logic [7:0] NV_MODE      = 8'h04;
  localparam logic [7:0] NV_RATE      = 8'h05;
  localparam logic [7:0] NV_XOFS_LO   = 8'h0e;
  // mode register fields and reset values
  localparam int unsigned OM_COMP     = 7;
  localparam int unsigned OM_CAL      = 6;
  localparam int unsigned OM_FILT     = 5;
  localparam int unsigned OM_RUN      = 4;
  localparam int unsigned OM_STBY     = 3;
  localparam logic [5:0] OM_WR_MASK   = 6'h3f;
  localparam logic [2:0] ORI_LEVEL    = 3'h1;
  localparam logic [2:0] ORI_EDGE     = 3'h2;
  localparam logic [2:0] ORI_FRONT    = 3'h4;
  localparam logic [7:0] OM1_RESET    = 8'h11;
  localparam logic [7:0] OM2_RESET    = 8'h01;
  localparam logic [1:0] RATE_1HZ     = 2'h0;
  localparam logic [1:0] RATE_5HZ     = 2'h1;
  localparam logic [1:0] RATE_10HZ    = 2'h2;
  // angle limits, tenths of a degree
  localparam logic signed [15:0] HEAD_MAX = 16'sh0e10;
  localparam logic signed [15:0] TILT_MAX = 16'sh0384;
  localparam int unsigned RESP_BYTES  = 6;

  typedef struct packed {
    logic signed [15:0] acc_x;
    logic signed [15:0] acc_y;
    logic signed [15:0] acc_z;
    logic signed [15:0] mag_x;
    logic signed [15:0] mag_y;
    logic signed [15:0] mag_z;
    logic signed [15:0] heading;
    logic signed [15:0] pitch;
    logic signed [15:0] roll;
    logic signed [15:0] temp;
  } ccs_sample_type;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } ccs_offset_type;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_ARG1 = 3'b010,
    ST_ARG2 = 3'b011,
    ST_BUSY = 3'b100
  } ccs_state_type;
endpackage

/* sim/ccs_seq_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module ccs_seq_checker #(
  parameter int unsigned DATA_CYC   = 10,
  parameter int unsigned SHORT_CYC  = 4,
  parameter int unsigned CALX_CYC   = 8,
  parameter int unsigned NV_CYC     = 9,
  parameter int unsigned RATE1_CYC  = 50,
  parameter int unsigned RATE5_CYC  = 20,
  parameter int unsigned RATE10_CYC = 10
) (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  // host side
  input wire logic       wr_valid_i,
  input wire logic       wr_first_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       rd_start_i,
  input wire logic       rd_req_i,
  input wire logic       rd_valid_o,
  input wire logic       busy_o,
  // mode view
  input wire logic       calc_busy_i,
  input wire logic       meas_tick_o,
  input wire logic [7:0] operating_mode_status_o,
  input wire logic [7:0] measurement_rate_config_o,
  input wire logic       sleep_o
);
  import ccs_pkg::*;
  localparam int SH_MAX = SHORT_CYC + 2;
  logic [7:0]  cmd_q, cmd_d;
  logic [15:0] len_q, len_d, gap_q, gap_d;
  logic [3:0]  cfg_q, cfg_d;
  logic        chg_q, chg_d, seen_q, seen_d;

  // zero: wait not checked
  function automatic logic [15:0] busy_len(input logic [7:0] c);
    case (c)
      CMD_ACCEL, CMD_MAG, CMD_HEAD, CMD_TILT, CMD_MODE: return 16'(DATA_CYC + 1);
      CMD_CAL_OUT: return 16'(CALX_CYC + 1);
      CMD_NV_RD, CMD_NV_WR: return 16'(NV_CYC + 1);
      8'h00, CMD_RESET, CMD_SLEEP, CMD_WAKE: return 16'h0;
      default: return 16'(SHORT_CYC + 1);
    endcase
  endfunction

  function automatic logic [15:0] tick_gap(input logic [1:0] r);
    case (r)
      RATE_1HZ: return 16'(RATE1_CYC);
      RATE_10HZ: return 16'(RATE10_CYC);
      default: return 16'(RATE5_CYC);
    endcase
  endfunction

  always_comb begin
    cmd_d  = (wr_valid_i && wr_first_i && !busy_o) ? wr_data_i : cmd_q;
    len_d  = busy_o ? len_q + 16'h1 : 16'h0;
    gap_d  = meas_tick_o ? 16'h1 : gap_q + 16'h1;
    cfg_d  = {measurement_rate_config_o[1:0], operating_mode_status_o[OM_RUN], sleep_o};
    chg_d  = meas_tick_o ? 1'b0 : (chg_q | (cfg_d != cfg_q));
    seen_d = seen_q | meas_tick_o;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_q  <= 8'h00;
      len_q  <= 16'h0;
      gap_q  <= 16'h0;
      cfg_q  <= 4'h0;
      chg_q  <= 1'b1;
      seen_q <= 1'b0;
    end else begin
      cmd_q  <= cmd_d;
      len_q  <= len_d;
      gap_q  <= gap_d;
      cfg_q  <= cfg_d;
      chg_q  <= chg_d;
      seen_q <= seen_d;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence cmd_seen(logic [7:0] c);
    wr_valid_i && wr_first_i && !busy_o && wr_data_i == c;
  endsequence
  sequence busy_end;
    $fell(busy_o) ##0 busy_len(cmd_q) != 16'h0;
  endsequence
  property sel_p(logic [7:0] c, logic [2:0] o);
    cmd_seen(c) |-> ##[1:SH_MAX] operating_mode_status_o[2:0] == o;
  endproperty

  read_answer_a: assert property (rd_req_i && !rd_start_i |=> rd_valid_o)
    else $error("read not answered");
  read_cause_a: assert property (rd_valid_o |-> $past(rd_req_i) && !$past(rd_start_i))
    else $error("read without request");
  busy_len_a: assert property (busy_end |-> len_q == busy_len(cmd_q))
    else $error("wrong wait length");
  level_sel_a: assert property (sel_p(CMD_LEVEL, ORI_LEVEL))
    else $error("level not set");
  edge_sel_a: assert property (sel_p(CMD_EDGE, ORI_EDGE))
    else $error("edge not set");
  front_sel_a: assert property (sel_p(CMD_FRONT, ORI_FRONT))
    else $error("front not set");
  comp_flag_a: assert property (operating_mode_status_o[OM_COMP] == calc_busy_i)
    else $error("compass flag wrong");
  cal_enter_a: assert property (cmd_seen(CMD_CAL_IN) |-> ##[1:SH_MAX] operating_mode_status_o[OM_CAL])
    else $error("cal flag not raised");
  cal_exit_a: assert property ($fell(busy_o) && cmd_q == CMD_CAL_OUT |-> ##[0:2] !operating_mode_status_o[OM_CAL])
    else $error("cal flag not cleared");
  tick_gap_a: assert property (meas_tick_o && seen_q && !chg_q && cfg_d == cfg_q |-> gap_q == tick_gap(cfg_q[3:2]))
    else $error("tick spacing wrong");
endmodule

bind ccs_sequencer ccs_seq_checker #(
  .DATA_CYC(DATA_CYC), .SHORT_CYC(SHORT_CYC), .CALX_CYC(CALX_CYC), .NV_CYC(NV_CYC),
  .RATE1_CYC(RATE1_CYC), .RATE5_CYC(RATE5_CYC), .RATE10_CYC(RATE10_CYC)
) ccs_seq_checker_inst (.*);
`default_nettype wire

/* sim/ccs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
  // clock
  input  wire logic       clk_sys_i,
  // answers from the device
  input  wire logic       busy_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  // requests to the device
  output logic            wr_valid_o,
  output logic            wr_first_o,
  output logic [7:0]      wr_data_o,
  output logic            rd_start_o,
  output logic            rd_req_o
);
  import ccs_pkg::*;
  initial begin
    {wr_valid_o, wr_first_o, wr_data_o, rd_start_o, rd_req_o} = '0;
  end

  task automatic wait_idle;
    int n = 0;
    @(negedge clk_sys_i);
    while (busy_i !== 1'b0 && n < 4000) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask

  // no idle check, so refusals can be provoked
  task automatic put(input logic [7:0] c, a1 = 8'h00, a2 = 8'h00, input int nargs = 0);
    @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    wr_valid_o <= 1'b1;
    wr_first_o <= 1'b1;
    wr_data_o  <= c;
    for (int i = 0; i < nargs; i++) begin
      @(posedge clk_sys_i);
      wr_first_o <= 1'b0;
      wr_data_o  <= (i == 0) ? a1 : a2;
    end
    @(posedge clk_sys_i);
    wr_valid_o <= 1'b0;
    wr_first_o <= 1'b0;
    wr_data_o  <= ~wr_data_o;
  endtask

  task automatic run_cmd(input logic [7:0] c, a1 = 8'h00, a2 = 8'h00, input int nargs = 0);
    wait_idle();
    put(c, a1, a2, nargs);
    wait_idle();
  endtask

  task automatic read_resp(input int n, output logic [7:0] got [8]);
    @(posedge clk_sys_i);
    rd_start_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_start_o <= 1'b0;
    rd_req_o   <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      rd_req_o <= (i < n - 1);
      @(negedge clk_sys_i);
      got[i] = rd_valid_i ? rd_data_i : 8'hxx;
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ccs_pkg::*;
  logic           clk_sys_i, reset_i, wr_valid_i, wr_first_i, rd_start_i, rd_req_i;
  logic           rd_valid_o, busy_o, sample_valid_i, calc_busy_i, meas_tick_o, sleep_o;
  logic [7:0]     wr_data_i, rd_data_o, operating_mode_status_o, measurement_rate_config_o;
  ccs_sample_type sample_i;
  ccs_offset_type hard_iron_o;
  logic [7:0]     rx [8];
  int             miscompares = 0;
  int             tests_run = 0;

  localparam int unsigned C_INIT = 20, C_DATA = 10, C_SHORT = 4, C_CALX = 8, C_NV = 9;
  localparam int unsigned C_R1 = 50, C_R5 = 20, C_R10 = 10;
  ccs_sequencer #(.INIT_CYC(C_INIT), .DATA_CYC(C_DATA), .SHORT_CYC(C_SHORT), .CALX_CYC(C_CALX),
    .NV_CYC(C_NV), .RATE1_CYC(C_R1), .RATE5_CYC(C_R5), .RATE10_CYC(C_R10)) ccs_sequencer_inst (
    .clk_sys_i, .reset_i, .wr_valid_i, .wr_first_i, .wr_data_i, .rd_start_i, .rd_req_i,
    .rd_valid_o, .rd_data_o, .busy_o, .sample_i, .sample_valid_i, .calc_busy_i, .meas_tick_o,
    .operating_mode_status_o, .measurement_rate_config_o, .sleep_o, .hard_iron_o);
  ccs_host_model ccs_host_model_inst (.clk_sys_i(clk_sys_i), .busy_i(busy_o),
    .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o), .wr_valid_o(wr_valid_i),
    .wr_first_o(wr_first_i), .wr_data_o(wr_data_i), .rd_start_o(rd_start_i),
    .rd_req_o(rd_req_i));

  task automatic check(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // heading, pitch past limits
  task automatic t_data;
    logic [7:0]  cmd [4];
    logic [15:0] w [4][3];
    cmd = '{CMD_ACCEL, CMD_MAG, CMD_HEAD, CMD_TILT};
    w = '{'{16'h1234, 16'h8765, 16'h0f0e}, '{16'h7001, 16'hfe02, 16'h0103},
          '{16'h0e10, 16'hfc7c, 16'h0100}, '{16'hfc7c, 16'h0100, 16'h00fa}};
    @(posedge clk_sys_i);
    sample_i <= '{16'h1234, 16'h8765, 16'h0f0e, 16'h7001, 16'hfe02, 16'h0103,
                  16'h0e74, 16'hfc18, 16'h0100, 16'h00fa};
    for (int k = 0; k < 4; k++) begin
      ccs_host_model_inst.run_cmd(cmd[k]);
      ccs_host_model_inst.read_resp(7, rx);
      for (int j = 0; j < 3; j++) begin
        check({rx[2*j], rx[2*j+1]}, w[k][j]);
      end
      check(rx[6], 8'h00);
    end
  endtask

  task automatic t_orient;
    logic [7:0] code [3];
    logic [2:0] ori [3];
    code = '{CMD_EDGE, CMD_FRONT, CMD_LEVEL};
    ori = '{ORI_EDGE, ORI_FRONT, ORI_LEVEL};
    for (int k = 0; k < 3; k++) begin
      ccs_host_model_inst.run_cmd(code[k]);
      check(operating_mode_status_o[2:0], ori[k]);
      ccs_host_model_inst.run_cmd(CMD_MODE);
      ccs_host_model_inst.read_resp(1, rx);
      check(rx[0], {5'h02, ori[k]});
    end
    // second command dropped while busy
    ccs_host_model_inst.put(CMD_MAG);
    ccs_host_model_inst.put(CMD_FRONT);
    ccs_host_model_inst.wait_idle();
    check(operating_mode_status_o[2:0], ORI_LEVEL);
  endtask

  task automatic t_status;
    ccs_host_model_inst.run_cmd(CMD_NV_WR, NV_MODE, 8'hf1, 2);
    check(operating_mode_status_o, 8'h31);
    @(posedge clk_sys_i);
    calc_busy_i <= 1'b1;
    @(negedge clk_sys_i);
    check(operating_mode_status_o[7], 1'b1);
    @(posedge clk_sys_i);
    calc_busy_i <= 1'b0;
  endtask

  task automatic t_rate;
    logic [1:0] rc [3];
    int         gap [3];
    int         n;
    rc = '{RATE_10HZ, RATE_1HZ, RATE_5HZ};
    gap = '{C_R10, C_R1, C_R5};
    for (int k = 0; k < 3; k++) begin
      ccs_host_model_inst.run_cmd(CMD_NV_WR, NV_RATE, {6'h00, rc[k]}, 2);
      check(measurement_rate_config_o, {6'h00, rc[k]});
      for (int m = 0; m < 2; m++) begin
        n = 0;
        do begin
          @(negedge clk_sys_i);
          n++;
        end while (meas_tick_o !== 1'b1 && n < 200);
      end
      check(16'(n), 16'(gap[k]));
    end
    ccs_host_model_inst.run_cmd(CMD_NV_RD, NV_RATE, 8'h00, 1);
    ccs_host_model_inst.read_resp(1, rx);
    check(rx[0], 8'h01);
  endtask

  task automatic t_standby;
    int n = 0;
    ccs_host_model_inst.run_cmd(CMD_STBY);
    check(operating_mode_status_o[4:3], 2'b01);
    repeat (60) begin
      @(negedge clk_sys_i);
      if (meas_tick_o !== 1'b0) n++;
    end
    check(16'(n), 16'h0);
    ccs_host_model_inst.run_cmd(CMD_RUN);
    check(operating_mode_status_o[4:3], 2'b10);
  endtask

  task automatic t_cal;
    @(posedge clk_sys_i);
    {sample_i.mag_x, sample_i.mag_y, sample_i.mag_z} <= 48'h0064_0032_ffc4;
    ccs_host_model_inst.run_cmd(CMD_CAL_IN);
    check(operating_mode_status_o[6], 1'b1);
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    {sample_i.mag_x, sample_i.mag_y, sample_i.mag_z} <= 48'hffec_000a_ff9c;
    @(posedge clk_sys_i);
    sample_valid_i <= 1'b0;
    ccs_host_model_inst.run_cmd(CMD_CAL_OUT);
    check(operating_mode_status_o[6], 1'b0);
    check(hard_iron_o.x, 16'h0028);
    check(hard_iron_o.y, 16'h001e);
    check(hard_iron_o.z, 16'hffb0);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // run needs several hundred cycles
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  initial begin
    reset_i = 1'b1;
    sample_i = '0;
    sample_valid_i = 1'b0;
    calc_busy_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    check(operating_mode_status_o, OM1_RESET);
    check(measurement_rate_config_o, OM2_RESET);
    check(busy_o, 1'b1);
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_data();
    t_orient();
    t_status();
    t_rate();
    t_standby();
    t_cal();
    finish_test();
  end
endmodule
`default_nettype wire
